// file: lcu_top.sv
// serial control, data and baud block with AXI4-Lite register access
// assumes rxd synchronous to clk and a single AXI4-Lite master
//
// Summary of operation
// R1: transmit-empty flag raises interrupt when enabled
// R2: transmission-done flag raises interrupt when enabled
// R3: overrun or receive-ready flag raises interrupt while receive interrupt enable set
// R4: quiet-line flag raises interrupt when enabled
// R5: transmitter enable toggled low then high mid-word queues one idle preamble
// R6: transmitter waits one bit time after enable before sending
// R7: receiver enable starts start-bit search; clear disables receiver
// R8: mute bit set by software, cleared by hardware on wake-up
// R9: address-mark wake-up: mute writes ignored while receive-ready is set
// R10: software receives one byte before muting with idle-line wake-up
// R11: break bit sends breaks; set then cleared sends one break word
// R12: data address reads receive holding, writes transmit holding
// R13: first prescaler field selects factor 1, 3, 4 or 13
// R14: transmit divisor field selects power of two 1 to 128
// R15: receive divider field selects power of two 1 to 128
// R16: nonzero extended receive divider replaces receive power-of-two factor
// R17: nonzero extended transmit divider replaces transmit power-of-two factor
// R18: LIN mode aliases LIN divider and fraction registers
// R19: software clears word length and sets LIN enable to enter LIN
// R20: LIN master break sends 13 low bits with conventional baud
// R21: LIN slave ignores break bit and uses one shared LIN generator
// R22: software configures LIN mode before writing LIN baud registers
// R23: master header: break, clear break, 0x55, wait empty, identifier
// R24: empty flag set on transfer to shifter, cleared by status then write
// R25: word length selects 8 or 9 data bits between start and stop
// R26: rate is bus clock over prescaler, over 16, over selected factor
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`include "lcu_map.svh"
`timescale 1ns/100ps
module lcu_top import lcu_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial line and interrupt
    input wire logic rxd,
    output logic txd,
    output logic irq
);
    // ==========================================================
    // state record and derived terms
    lcu_st_t s;
    lcu_st_t n;
    logic lin_mode, lin_slave, word9, wake_addr, te, sbk_eff, rx_on;
    logic pre_tick, conv_t, conv_r, lin_tick, t_os, r_os, bit_end_t;
    logic wr_go, rd_go, wr_hit, rd_hit, muted, stop_bad;
    logic [3:0] pr, nbits, frame_len, brk_len, tx_len;
    logic [7:0] t_lim, r_lim, flags, qlim;
    logic [8:0] lin_lim;
    logic [4:0] acc_sum;

    // first prescaler factor table
    function automatic logic [3:0] pre_factor(input logic [1:0] sel);
        unique case (sel)
            2'b00: pre_factor = `LCU_PR_F0;
            2'b01: pre_factor = `LCU_PR_F1;
            2'b10: pre_factor = `LCU_PR_F2;
            2'b11: pre_factor = `LCU_PR_F3;
        endcase
    endfunction

    // mode and framing selections
    assign lin_mode = s.cr3[`LCU_LIN_ON];
    assign lin_slave = lin_mode & s.cr3[`LCU_LIN_FOLLOWER_SEL];
    assign word9 = s.cr1[`LCU_WORD9];
    assign wake_addr = s.cr1[`LCU_WAKE_ADDR];
    assign te = s.cr2[`LCU_TX_ON];
    assign rx_on = s.cr2[`LCU_RX_ON];
    assign sbk_eff = s.cr2[`LCU_BREAK_SEND] & ~lin_slave; // R21
    assign nbits = word9 ? `LCU_BITS9 : `LCU_BITS8; // R25
    assign frame_len = word9 ? `LCU_FRAME9 : `LCU_FRAME8; // R25
    assign brk_len = (lin_mode & ~lin_slave) ? `LCU_BRK_LIN : frame_len; // R20
    assign qlim = {frame_len, 4'h0};
    assign flags = {s.tx_holding_empty, s.tc, s.rx_ready_flag, s.idle, s.ovr, 1'b0, s.fe, 1'b0};

    // conventional and extended generators give 16x oversample ticks
    assign pr = pre_factor(s.brr[7:6]); // R13
    assign pre_tick = (s.pre_cnt >= pr - 4'd1);
    assign t_lim = (s.ext_tx_div != 8'h00) ? s.ext_tx_div : (8'h01 << s.brr[5:3]); // R14 R17
    assign r_lim = (s.ext_rx_div != 8'h00) ? s.ext_rx_div : (8'h01 << s.brr[2:0]); // R15 R16
    assign conv_t = pre_tick & (s.tdiv_cnt >= t_lim - 8'h01); // R26
    assign conv_r = pre_tick & (s.rdiv_cnt >= r_lim - 8'h01); // R26

    // lin generator: lpr clocks per tick, fraction adds a clock now and then
    assign lin_lim = {1'b0, s.lin_baud_div} + {8'h00, s.lin_xtra};
    assign lin_tick = (s.lin_baud_div != 8'h00) & (s.lin_cnt >= lin_lim - 9'h001);
    assign t_os = lin_slave ? lin_tick : conv_t; // R21
    assign r_os = lin_slave ? lin_tick : conv_r; // R21
    assign bit_end_t = t_os & (s.tx_os == `LCU_OS_LAST);

    // bus handshakes
    assign wr_go = s.aw_have & s.w_have & ~s.bvalid;
    assign rd_go = arvalid & ~s.rvalid;
    assign wr_hit = (s.aw_addr[7:5] == 3'b000) & (s.aw_addr[1:0] == 2'b00);
    assign rd_hit = (araddr[7:5] == 3'b000) & (araddr[1:0] == 2'b00);
    assign muted = s.cr2[`LCU_RX_MUTE];
    assign stop_bad = ~rxd;

    // transmit length of the running state
    always_comb begin
        unique case (s.tst)
            TX_WAIT: tx_len = 4'd1; // R6
            TX_BRK: tx_len = brk_len;
            default: tx_len = frame_len;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        acc_sum = {1'b0, s.lin_acc} + {1'b0, s.lin_baud_frac};
        n = s;
        // baud dividers
        n.pre_cnt = pre_tick ? 4'h0 : s.pre_cnt + 4'd1;
        if (pre_tick) begin
            n.tdiv_cnt = conv_t ? 8'h00 : s.tdiv_cnt + 8'h01;
            n.rdiv_cnt = conv_r ? 8'h00 : s.rdiv_cnt + 8'h01;
        end
        if (s.lin_baud_div == 8'h00) begin
            n.lin_cnt = 9'h000;
        end else if (lin_tick) begin
            n.lin_cnt = 9'h000;
            n.lin_acc = acc_sum[3:0];
            n.lin_xtra = acc_sum[4];
        end else begin
            n.lin_cnt = s.lin_cnt + 9'h001;
        end
        // bus address and data capture
        if (awvalid & ~s.aw_have) begin
            n.aw_have = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid & ~s.w_have) begin
            n.w_have = 1'b1;
            n.wdata = wdata[7:0];
            n.wstrb0 = wstrb[0];
        end
        if (s.bvalid & bready) begin
            n.bvalid = 1'b0;
        end
        if (s.rvalid & rready) begin
            n.rvalid = 1'b0;
        end
        // register write
        if (wr_go) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_hit ? `LCU_RESP_OKAY : `LCU_RESP_SLVERR;
            if (wr_hit & s.wstrb0) begin
                unique case (s.aw_addr)
                    `LCU_OFS_DATA: begin
                        n.tx_hold = s.wdata; // R12
                        if (s.armed) begin
                            n.tx_holding_empty = 1'b0; // R24
                            n.tc = 1'b0;
                            n.armed = 1'b0;
                        end
                    end
                    `LCU_OFS_BAUD: begin
                        if (lin_mode) begin
                            n.lin_baud_div = s.wdata; // R18
                        end else begin
                            n.brr = s.wdata;
                        end
                    end
                    `LCU_OFS_CR1: n.cr1 = {s.cr1[`LCU_RX_BIT8], s.wdata[6:0]};
                    `LCU_OFS_CR2: begin
                        n.cr2 = s.wdata; // R8
                        if (wake_addr & s.rx_ready_flag) begin
                            n.cr2[`LCU_RX_MUTE] = muted; // R9
                        end
                    end
                    `LCU_OFS_CR3: n.cr3 = s.wdata;
                    `LCU_OFS_ERX: begin
                        if (!lin_mode) begin
                            n.ext_rx_div = s.wdata; // R16
                        end
                    end
                    `LCU_OFS_ETX: begin
                        if (lin_mode) begin
                            n.lin_baud_frac = s.wdata[3:0]; // R18
                        end else begin
                            n.ext_tx_div = s.wdata; // R17
                        end
                    end
                    default: ;
                endcase
            end
        end
        // register read, with the flag clearing sequence
        if (rd_go) begin
            n.rvalid = 1'b1;
            n.rresp = rd_hit ? `LCU_RESP_OKAY : `LCU_RESP_SLVERR;
            n.rdata = 8'h00;
            unique case (araddr)
                `LCU_OFS_FLAGS: begin
                    n.rdata = flags;
                    n.armed = 1'b1;
                end
                `LCU_OFS_DATA: begin
                    n.rdata = s.rx_hold; // R12
                    if (s.armed) begin
                        n.rx_ready_flag = 1'b0;
                        n.idle = 1'b0;
                        n.ovr = 1'b0;
                        n.fe = 1'b0;
                        n.armed = 1'b0;
                    end
                end
                `LCU_OFS_BAUD: n.rdata = lin_mode ? s.lin_baud_div : s.brr; // R18
                `LCU_OFS_CR1: n.rdata = s.cr1;
                `LCU_OFS_CR2: n.rdata = s.cr2;
                `LCU_OFS_CR3: n.rdata = s.cr3;
                `LCU_OFS_ERX: n.rdata = lin_mode ? 8'h00 : s.ext_rx_div; // R18
                `LCU_OFS_ETX: n.rdata = lin_mode ? {4'h0, s.lin_baud_frac} : s.ext_tx_div; // R18
                default: ;
            endcase
        end
        // ======================================================
        // transmitter; hardware sets come after the software clears
        n.te_d = te;
        n.sbk_d = sbk_eff;
        if (sbk_eff & ~s.sbk_d) begin
            n.pend_brk = 1'b1; // R11
        end
        if (te & ~s.te_d & (s.tst != TX_IDLE)) begin
            n.pend_pre = 1'b1; // R5
        end
        if ((s.tst != TX_IDLE) & t_os) begin
            n.tx_os = s.tx_os + 4'd1;
            if (s.tx_os == `LCU_OS_LAST) begin
                n.tx_bits = s.tx_bits + 4'd1;
                n.tx_sh = {1'b1, s.tx_sh[10:1]};
            end
        end
        unique case (s.tst)
            TX_IDLE: begin
                n.tx_os = 4'h0;
                n.tx_bits = 4'h0;
                if (te & ~s.te_d) begin
                    n.tst = TX_WAIT; // R6
                end else if (te & (sbk_eff | s.pend_brk)) begin
                    n.tst = TX_BRK; // R11
                end else if (te & s.pend_pre) begin
                    n.tst = TX_PRE; // R5
                end else if (te & ~s.tx_holding_empty) begin
                    n.tst = TX_DATA;
                    n.tx_sh = {1'b1, ~word9 | s.cr1[`LCU_TX_BIT8], s.tx_hold, 1'b0};
                    n.tx_holding_empty = 1'b1; // R24
                end
            end
            TX_WAIT, TX_PRE, TX_BRK, TX_DATA: begin
                if (bit_end_t & (s.tx_bits == tx_len - 4'd1)) begin
                    n.tst = TX_IDLE;
                    if (s.tst == TX_PRE) begin
                        n.pend_pre = 1'b0;
                    end
                    if (s.tst == TX_BRK) begin
                        n.pend_brk = 1'b0; // R11
                    end
                    if ((s.tst == TX_DATA) & s.tx_holding_empty) begin
                        n.tc = 1'b1;
                    end
                end
            end
            default: n.tst = TX_IDLE;
        endcase
        // line level follows the next state
        unique case (n.tst)
            TX_BRK: n.txd = 1'b0; // R20
            TX_DATA: n.txd = n.tx_sh[0];
            default: n.txd = 1'b1;
        endcase
        // ======================================================
        // receiver
        if (!rx_on) begin
            n.rxst = RX_IDLE; // R7
            n.rx_os = 4'h0;
            n.quiet = 8'h00;
        end else if (r_os) begin
            unique case (s.rxst)
                RX_IDLE: begin
                    n.rx_os = 4'h0;
                    if (!rxd) begin
                        n.rxst = RX_START; // R7
                        n.quiet = 8'h00;
                    end else if (s.quiet != qlim) begin
                        n.quiet = s.quiet + 8'h01;
                        if (s.quiet == qlim - 8'h01) begin
                            if (muted & ~wake_addr) begin
                                n.cr2[`LCU_RX_MUTE] = 1'b0; // R8
                            end else if (s.idle_arm) begin
                                n.idle = 1'b1;
                                n.idle_arm = 1'b0;
                            end
                        end
                    end
                end
                RX_START: begin
                    n.rx_os = s.rx_os + 4'd1;
                    if (s.rx_os == `LCU_OS_MID) begin
                        n.rxst = rxd ? RX_IDLE : RX_DATA;
                        n.rx_os = 4'h0;
                        n.rx_bits = 4'h0;
                    end
                end
                RX_DATA: begin
                    n.rx_os = s.rx_os + 4'd1;
                    if (s.rx_os == `LCU_OS_LAST) begin
                        n.rx_bits = s.rx_bits + 4'd1;
                        if (s.rx_bits != nbits) begin
                            n.rx_sh = {rxd, s.rx_sh[8:1]}; // R25
                        end else begin
                            n.rxst = RX_IDLE;
                            if (muted & wake_addr & s.rx_sh[8]) begin
                                n.cr2[`LCU_RX_MUTE] = 1'b0; // R8
                            end
                            if (!muted | (wake_addr & s.rx_sh[8])) begin
                                if (s.rx_ready_flag) begin
                                    n.ovr = 1'b1;
                                end else begin
                                    n.rx_hold = word9 ? s.rx_sh[7:0] : s.rx_sh[8:1];
                                    n.cr1[`LCU_RX_BIT8] = word9 & s.rx_sh[8];
                                    n.rx_ready_flag = 1'b1;
                                    n.fe = stop_bad;
                                    n.idle_arm = 1'b1;
                                end
                            end
                        end
                    end
                end
                default: n.rxst = RX_IDLE;
            endcase
        end
        // shared serial interrupt
        n.irq = (n.cr2[`LCU_TX_EMPTY_IRQ_ON] & n.tx_holding_empty) | // R1
            (n.cr2[`LCU_TX_DONE_IRQ_ON] & n.tc) | // R2
            (n.cr2[`LCU_RX_IRQ_ON] & (n.ovr | n.rx_ready_flag)) | // R3
            (n.cr2[`LCU_QUIET_LINE_IRQ_ON] & n.idle); // R4
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.tx_holding_empty <= 1'b1;
            s.tc <= 1'b1;
            s.txd <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // outputs
    assign awready = ~s.aw_have;
    assign wready = ~s.w_have;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = ~s.rvalid;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = {24'h000000, s.rdata};
    assign txd = s.txd;
    assign irq = s.irq;
endmodule // lcu_top

// file: lcu_map.svh
// register offsets, field positions and counts of the serial block
// assumes byte addresses on an 8-bit AXI4-Lite address
`ifndef LCU_MAP_SVH
`define LCU_MAP_SVH
// byte offsets
`define LCU_OFS_FLAGS 8'h00
`define LCU_OFS_DATA 8'h04
`define LCU_OFS_BAUD 8'h08
`define LCU_OFS_CR1 8'h0c
`define LCU_OFS_CR2 8'h10
`define LCU_OFS_CR3 8'h14
`define LCU_OFS_ERX 8'h18
`define LCU_OFS_ETX 8'h1c
// serial_control_two fields
`define LCU_TX_EMPTY_IRQ_ON 7
`define LCU_TX_DONE_IRQ_ON 6
`define LCU_RX_IRQ_ON 5
`define LCU_QUIET_LINE_IRQ_ON 4
`define LCU_TX_ON 3
`define LCU_RX_ON 2
`define LCU_RX_MUTE 1
`define LCU_BREAK_SEND 0
// serial_control_one and serial_control_three fields
`define LCU_RX_BIT8 7
`define LCU_TX_BIT8 6
`define LCU_WORD9 4
`define LCU_WAKE_ADDR 3
`define LCU_LIN_ON 6
`define LCU_LIN_FOLLOWER_SEL 5
// first prescaler factors
`define LCU_PR_F0 4'd1
`define LCU_PR_F1 4'd3
`define LCU_PR_F2 4'd4
`define LCU_PR_F3 4'd13
// frame and timing counts
`define LCU_OS_LAST 4'hf
`define LCU_OS_MID 4'h7
`define LCU_BRK_LIN 4'd13
`define LCU_BITS8 4'd8
`define LCU_BITS9 4'd9
`define LCU_FRAME8 4'd10
`define LCU_FRAME9 4'd11
// bus answers
`define LCU_RESP_OKAY 2'b00
`define LCU_RESP_SLVERR 2'b10
`endif

// file: lcu_pkg.sv
// types of the serial block: states and the packed state record
// assumes the offsets and counts of lcu_map.svh
package lcu_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_PRE, TX_BRK, TX_DATA} lcu_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} lcu_rx_t;
    typedef struct packed {
        logic aw_have; logic [7:0] aw_addr; logic w_have; logic [7:0] wdata; logic wstrb0;
        logic bvalid; logic [1:0] bresp; logic rvalid; logic [7:0] rdata; logic [1:0] rresp;
        logic [7:0] cr1; logic [7:0] cr2; logic [7:0] cr3; logic [7:0] brr;
        logic [7:0] ext_rx_div; logic [7:0] ext_tx_div; logic [7:0] lin_baud_div; logic [3:0] lin_baud_frac;
        logic tx_holding_empty; logic tc; logic rx_ready_flag; logic idle; logic ovr; logic fe;
        logic armed; logic idle_arm;
        lcu_tx_t tst; logic [7:0] tx_hold; logic [10:0] tx_sh;
        logic [3:0] tx_bits; logic [3:0] tx_os;
        logic te_d; logic sbk_d; logic pend_pre; logic pend_brk; logic txd;
        lcu_rx_t rxst; logic [7:0] rx_hold; logic [8:0] rx_sh;
        logic [3:0] rx_bits; logic [3:0] rx_os; logic [7:0] quiet;
        logic [3:0] pre_cnt; logic [7:0] tdiv_cnt; logic [7:0] rdiv_cnt;
        logic [8:0] lin_cnt; logic [3:0] lin_acc; logic lin_xtra;
        logic irq;
    } lcu_st_t;
endpackage

// file: lcu_checker.sv
// checker of bus handshakes and serial line timing
// assumes binding onto lcu_top, one clock clk, reset rst
`timescale 1ns/100ps
module lcu_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // serial line
    input wire logic txd
);
    logic [9:0] low_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // length of the current low run on txd, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_r <= 10'h000;
        end else begin
            low_r <= txd ? 10'h000 : low_r + {9'h000, ~&low_r};
        end
    end
    chk_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed before rready");
    chk_rd_drop: assert property (rvalid && rready |=> !rvalid)
        else $error("rvalid stayed after rready");
    chk_rd_lat: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    chk_rd_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer changed before bready");
    chk_wr_lat: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write answer late");
    chk_aw_held: assert property (awvalid && awready |=> !awready)
        else $error("address accepted while one held");
    chk_w_held: assert property (wvalid && wready |=> !wready)
        else $error("data accepted while one held");
    chk_bit_len: assert property ($rose(txd) |-> low_r >= 10'd16)
        else $error("low bit shorter than sixteen clocks");
endmodule // lcu_checker
bind lcu_top lcu_checker chk (.*);

// file: lcu_line_model.sv
// remote serial node: sends frames on rxd, decodes and times txd
// assumes idle-high line and clk of the design
`timescale 1ns/100ps
module lcu_line_model (
    // clock
    input wire logic clk,
    // serial lines
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1;
    // one frame, lsb first, line left high after stop
    task automatic send(input logic [7:0] b, input int clks);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (clks) @(posedge clk);
        end
    endtask
    // decode one frame, counting idle clocks before it
    task automatic recv(output logic [7:0] b, output logic s, output int idle, input int clks);
        b = 8'h00;
        idle = 0;
        while (txd && idle < 4000) begin @(negedge clk); idle++; end
        repeat (clks / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin repeat (clks) @(negedge clk); b[i] = txd; end
        repeat (clks) @(negedge clk);
        s = txd;
    endtask
    // clocks of the next low run on txd
    task automatic low_run(output int len);
        int n;
        n = 0;
        len = 0;
        while (txd && n < 4000) begin @(negedge clk); n++; end
        while (!txd && len < 4000) begin @(negedge clk); len++; end
    endtask
endmodule // lcu_line_model

// file: lin_capable_uart_control_test.sv
// self-checking bench of lcu_top
// assumes lcu_line_model on the serial pins and lcu_checker bound
`include "lcu_map.svh"
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module lin_capable_uart_control_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rxd, txd, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int bad_count = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    lcu_top dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rxd(rxd), .txd(txd), .irq(irq));
    lcu_line_model line (.clk(clk), .txd(txd), .rxd(rxd));
    // =====================================================
    // verdict and bus tasks
    task automatic end_sim;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 60);
        r = bresp;
        bready <= 1'b0;
        if (!bvalid) begin bad_count++; end_sim(); end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 60);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
        if (!rvalid) begin bad_count++; end_sim(); end
    endtask
    // =====================================================
    // scenarios
    task automatic t_reset;
        logic [7:0] d;
        logic [1:0] r;
        for (int i = 0; i < 8; i++) begin
            if (i != 1) begin
                rd(8'(i * 4), d, r);
                `CHK("reset value", i == 0 ? 8'hc0 : 8'h00, d)
            end
        end
        rd(8'h20, d, r);
        `CHK("unmapped read", `LCU_RESP_SLVERR, r)
        wr(8'h20, 8'h5a, r);
        `CHK("unmapped write", `LCU_RESP_SLVERR, r)
    endtask
    task automatic t_irq;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            wr(`LCU_OFS_CR2, i == 0 ? 8'h80 : (i == 1 ? 8'h30 : (i == 2 ? 8'h40 : 8'h00)), r);
            repeat (2) @(negedge clk);
            `CHK("irq level", ~i[0], irq)
        end
    endtask
    task automatic t_tx;
        logic [7:0] d, b;
        logic [1:0] r;
        logic s;
        int idle;
        rd(`LCU_OFS_FLAGS, d, r);
        wr(`LCU_OFS_DATA, 8'ha5, r);
        fork
            line.recv(b, s, idle, 16);
            wr(`LCU_OFS_CR2, 8'h08, r);
        join
        `CHK("tx byte", 8'ha5, b)
        `CHK("tx stop", 1'b1, s)
        `CHK("tx delay", 1'b1, idle >= 16)
        repeat (20) @(negedge clk);
        rd(`LCU_OFS_FLAGS, d, r);
        `CHK("tx flags", 2'b11, d[7:6])
    endtask
    task automatic t_rate;
        logic [7:0] d;
        logic [1:0] r;
        int len;
        for (int i = 0; i < 3; i++) begin
            wr(`LCU_OFS_BAUD, i == 0 ? 8'h08 : (i == 1 ? 8'h40 : 8'h00), r);
            wr(`LCU_OFS_ETX, i == 2 ? 8'h05 : 8'h00, r);
            rd(`LCU_OFS_FLAGS, d, r);
            fork
                begin
                    line.low_run(len);
                    line.low_run(len); // d1, a whole bit
                end
                wr(`LCU_OFS_DATA, 8'hfd, r);
            join
            `CHK("bit clocks", i == 0 ? 32 : (i == 1 ? 48 : 80), len)
        end
        repeat (900) @(negedge clk);
        wr(`LCU_OFS_ETX, 8'h00, r);
    endtask
    task automatic t_rx;
        logic [7:0] d;
        logic [1:0] r;
        int n;
        line.send(8'h11, 16);
        rd(`LCU_OFS_FLAGS, d, r);
        `CHK("rx off", 1'b0, d[5])
        wr(`LCU_OFS_CR2, 8'h24, r);
        line.send(8'h3c, 16);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        `CHK("rx irq", 1'b1, irq)
        wr(`LCU_OFS_CR1, 8'h08, r);
        wr(`LCU_OFS_CR2, 8'h26, r);
        rd(`LCU_OFS_CR2, d, r);
        `CHK("mute locked", 8'h24, d)
        wr(`LCU_OFS_CR1, 8'h00, r);
        rd(`LCU_OFS_FLAGS, d, r);
        rd(`LCU_OFS_DATA, d, r);
        `CHK("rx byte", 8'h3c, d)
        repeat (3) @(negedge clk);
        `CHK("rx irq off", 1'b0, irq)
        wr(`LCU_OFS_CR2, 8'h26, r);
        rd(`LCU_OFS_CR2, d, r);
        `CHK("mute set", 8'h26, d)
    endtask
    task automatic t_lin;
        logic [7:0] d;
        logic [1:0] r;
        int len, n;
        wr(`LCU_OFS_ERX, 8'h55, r);
        wr(`LCU_OFS_CR3, 8'h40, r);
        rd(`LCU_OFS_ERX, d, r);
        `CHK("lin alias", 8'h00, d)
        fork
            line.low_run(len);
            begin
                wr(`LCU_OFS_CR2, 8'h09, r);
                wr(`LCU_OFS_CR2, 8'h08, r);
            end
        join
        `CHK("break clocks", 208, len)
        repeat (600) @(negedge clk);
        wr(`LCU_OFS_CR3, 8'h60, r);
        wr(`LCU_OFS_BAUD, 8'h01, r);
        wr(`LCU_OFS_CR2, 8'h09, r);
        n = 0;
        repeat (300) begin @(negedge clk); n += int'(txd === 1'b1); end
        `CHK("slave break", 300, n)
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_irq();
        t_tx();
        t_rate();
        t_rx();
        t_lin();
        end_sim();
    end
endmodule // lin_capable_uart_control_test
